// >>> common/rcs_pkg.sv
/*
 * Constants and carrier types for the reset-cause and core-state logic.
 * Assumes a single 20 MHz clock domain and a synchronous active-high reset.
 */
`default_nettype none
package rcs_pkg;
	// Clock rate
	localparam int unsigned CLK_HZ = 20_000_000;
	// Readiness delay, longest printed figure in microseconds
	localparam int unsigned READY_US = 10;
	localparam int unsigned READY_CYC = (READY_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
		READY_US * (CLK_HZ / 1_000_000);
	localparam int unsigned READY_W = 8;
	// Program counter
	localparam int unsigned PC_W = 13;
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [12:0] PC_VECTOR = 13'h0004;
	localparam logic [12:0] PC_STEP = 13'h0001;
	// Watchdog counter and prescaler width
	localparam int unsigned WDOG_W = 8;
	localparam int unsigned WPRE_W = 16;
	localparam logic [7:0] WDOG_CLEAR = 8'h00;
	localparam logic [15:0] WPRE_CLEAR = 16'h0000;
	// Register file of preserved and resettable words
	localparam int unsigned DATA_W = 8;
	localparam int unsigned KEEP_DEPTH = 16;
	localparam int unsigned KEEP_AW = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Wake flag widths
	localparam int unsigned IFLAG_W = 8;
	localparam logic [7:0] IFLAG_CLEAR = 8'h00;

	// Event causes, one-hot
	typedef enum logic [6:0] {
		RCS_EV_NONE   = 7'b0000001,
		RCS_EV_POR    = 7'b0000010,
		RCS_EV_EXTERNAL_MASTER_CLEAR   = 7'b0000100,
		RCS_EV_EXTERNAL_MASTER_CLEAR_S = 7'b0001000,
		RCS_EV_WDT    = 7'b0010000,
		RCS_EV_WDT_S  = 7'b0100000,
		RCS_EV_BOR    = 7'b1000000
	} rcs_cause_t;

	// Core sequencing states, one-hot
	typedef enum logic [3:0] {
		RCS_ST_HOLD  = 4'b0001,
		RCS_ST_RUN   = 4'b0010,
		RCS_ST_SLEEP = 4'b0100,
		RCS_ST_WAKE  = 4'b1000
	} rcs_state_t;

	// Status seen by software
	typedef struct packed {
		logic timeout;      // Time-out status bit
		logic powerdown;    // Power-down status bit
		logic por_n;        // Cleared by power-on
		logic bor_n;        // Cleared by brown-out
	} rcs_status_t;

	// Wake-up flag sets from the peripherals
	typedef struct packed {
		logic [7:0] interrupt_control_reg;
		logic [7:0] pflag1;
		logic [7:0] pflag2;
	} rcs_flags_t;

	// Readiness delay down-count step
	function automatic logic [7:0] rcs_dec(input logic [7:0] v);
		rcs_dec = (v == 8'h00) ? 8'h00 : v - 8'h01;
	endfunction : rcs_dec
endpackage : rcs_pkg
`default_nettype wire

// >>> hw/rcs_sync.sv
/*
 * Two-stage synchroniser for asynchronous level inputs.
 * Assumes one clock; the first stage feeds only the second.
 */
`timescale 1ns/1ns
`default_nettype none
module rcs_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clk,          // System clock
	input wire logic rst,          // Sync reset, active high
	input wire logic ce,           // Clock enable
	input wire logic [W-1:0] d,    // Async input
	output logic [W-1:0] q         // Synchronised level
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s1_d;
	logic [W-1:0] q_d;

	// Next values
	always_comb begin
		s1_d = ce ? d : s1_q;
		q_d = ce ? s1_q : q;
	end

	// Registers, reset low
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= '0;
			q <= '0;
		end else begin
			s1_q <= s1_d;
			q <= q_d;
		end
	end
endmodule : rcs_sync
`default_nettype wire

// >>> hw/rcs_keep_mem.sv
/*
 * Small register store that no reset initialises.
 * Assumes one clock; read data come out of a register.
 */
`timescale 1ns/1ns
`default_nettype none
module rcs_keep_mem #(
	parameter int unsigned DW = rcs_pkg::DATA_W,
	parameter int unsigned DEPTH = rcs_pkg::KEEP_DEPTH,
	parameter int unsigned AW = rcs_pkg::KEEP_AW
) (
	input wire logic clk,          // System clock
	input wire logic ce,           // Clock enable
	input wire logic we,           // Write strobe
	input wire logic [AW-1:0] addr, // Word address
	input wire logic [DW-1:0] wdata, // Write data
	output logic [DW-1:0] rdata    // Registered read data
);
	logic [DW-1:0] mem [DEPTH];

	// No reset at all: contents survive every reset type
	always_ff @(posedge clk) begin
		if (ce && we) begin
			mem[addr] <= wdata;
		end
		if (ce) begin
			rdata <= mem[addr];
		end
	end
endmodule : rcs_keep_mem
`default_nettype wire

// >>> hw/rcs_core.sv
/*
 * Reset cause and core state logic: sorts reset and wake events, sets the
 * program counter and the status bits, holds the core in reset until the
 * readiness delay ends, and keeps a store untouched by reset.
 * Assumes the master-clear, brown-out and power-on pins are asynchronous;
 * watchdog, sleep and interrupt signals come from the same clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// (RL1) Six events are told apart: power-on, master clear running, master clear asleep, watchdog running, watchdog wake, brown-out.
// (RL2) A store of registers is never initialised by reset and keeps its content through all resets.
// (RL3) All other registers load reset values on every reset except a watchdog wake.
// (RL4) A watchdog wake from sleep loads no reset values and resumes execution.
// (RL5) After power-on, brown-out or wake from sleep the core waits a readiness delay before running.
// (RL6) Each cause leaves a time-out and power-down pair, brown-out the same one as power-on; power-on sets both and clears the PC.
// (RL7) Master clear while running clears the PC and leaves both status bits unchanged.
// (RL8) Master clear during sleep clears the PC, sets time-out and clears power-down.
// (RL9) Watchdog reset while running clears the PC, clears time-out and sets power-down.
// (RL10) Watchdog wake continues at PC plus one and clears both status bits.
// (RL11) Interrupt wake continues at PC plus one, sets time-out and clears power-down.
// (RL12) Interrupt wake with global enable set loads the interrupt vector into the PC.
// (RL13) A wake updates only the interrupt flag bits that caused it.
// (RL14) The sleep instruction clears the watchdog and prescaler, sets time-out, clears power-down, stops the oscillator.
// (RL15) One power-control bit clears on brown-out, another on power-on, both kept on other resets.
// (RL16) All sources merge into one reset held until the delay ends, with cause bits captured before release.
module rcs_core #(
	parameter int unsigned READY_CYCLES = rcs_pkg::READY_CYC
) (
	input wire logic clk,                  // 20 MHz clock
	input wire logic rst,                  // Sync reset, treated as power-on
	input wire logic ce,                   // Clock enable, freezes state
	input wire logic external_master_clear_n, // Master clear pin, low active
	input wire logic brownout_reset,       // Supply monitor brown-out level
	input wire logic power_on_n,           // Supply monitor power-good, low = power-on
	input wire logic watchdog_timer_ovf,   // Watchdog overflow pulse
	input wire logic sleep_exec,           // Sleep instruction executed
	input wire logic irq_wake,             // Enabled interrupt pending
	input wire logic global_interrupt_enable, // Global interrupt enable
	input wire logic step_pc,              // Core advances PC
	input wire rcs_pkg::rcs_flags_t wake_flags, // Flag bits causing wake
	input wire logic [rcs_pkg::DATA_W-1:0] ctrl_wdata, // Register write data
	input wire logic ctrl_we,              // Resettable register write
	input wire logic keep_we,              // Preserved store write
	input wire logic [rcs_pkg::KEEP_AW-1:0] keep_addr, // Store address
	output logic core_reset,               // Merged internal reset
	output logic core_ready,               // Core may execute
	output logic osc_run,                  // Oscillator enable
	output logic [rcs_pkg::PC_W-1:0] pc,   // Program counter
	output rcs_pkg::rcs_status_t status,   // Status and power-control bits
	output rcs_pkg::rcs_cause_t last_cause, // Last recorded event
	output rcs_pkg::rcs_flags_t int_flags, // Interrupt flag registers
	output logic [rcs_pkg::WDOG_W-1:0] wdog_count, // Watchdog counter
	output logic [rcs_pkg::WPRE_W-1:0] wdog_pre, // Watchdog prescaler
	output logic [rcs_pkg::DATA_W-1:0] ctrl_reg, // Resettable register
	output logic [rcs_pkg::DATA_W-1:0] keep_rdata // Preserved store data
);
	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic external_master_clear_s;
	logic bor_s;
	logic pwr_s;
	logic external_master_clear_act;
	logic bor_act;
	logic por_act;

	rcs_sync #(.W(3)) u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d({~external_master_clear_n, brownout_reset, ~power_on_n}),
		.q({external_master_clear_s, bor_s, pwr_s})
	);

	// Power-on covers the reset port too; power-on outranks brown-out
	assign por_act = rst | pwr_s;
	assign bor_act = bor_s & ~por_act;
	assign external_master_clear_act = external_master_clear_s & ~por_act & ~bor_s;

	////////////////////////////////////////////////////////////////////////
	// State, cause, PC and status
	rcs_pkg::rcs_state_t st_q, st_d;
	rcs_pkg::rcs_cause_t cause_q, cause_d;
	rcs_pkg::rcs_status_t stat_q, stat_d;
	logic [rcs_pkg::PC_W-1:0] pc_q, pc_d;
	logic [rcs_pkg::READY_W-1:0] dly_q, dly_d;
	logic hard_rst;

	// Any reset that reloads registers; watchdog wake is not one
	assign hard_rst = por_act | bor_act | external_master_clear_act |
		(watchdog_timer_ovf && st_q != rcs_pkg::RCS_ST_SLEEP); // RL3 RL4

	// Next-state logic for sequencing and recorded cause
	always_comb begin
		st_d = st_q;
		cause_d = cause_q;
		stat_d = stat_q;
		pc_d = pc_q;
		dly_d = rcs_pkg::rcs_dec(dly_q);
		if (por_act) begin
			cause_d = rcs_pkg::RCS_EV_POR; // RL1
			stat_d = '{timeout: 1'b1, powerdown: 1'b1, por_n: 1'b0, bor_n: 1'b1}; // RL6 RL15
			pc_d = rcs_pkg::PC_RESET; // RL6
			st_d = rcs_pkg::RCS_ST_HOLD;
			dly_d = READY_CYCLES[rcs_pkg::READY_W-1:0]; // RL5
		end else if (bor_act) begin
			cause_d = rcs_pkg::RCS_EV_BOR; // RL1
			stat_d.timeout = 1'b1;
			stat_d.powerdown = 1'b1;
			stat_d.bor_n = 1'b0; // RL15
			pc_d = rcs_pkg::PC_RESET;
			st_d = rcs_pkg::RCS_ST_HOLD;
			dly_d = READY_CYCLES[rcs_pkg::READY_W-1:0]; // RL5
		end else if (external_master_clear_act) begin
			pc_d = rcs_pkg::PC_RESET; // RL7 RL8
			if (st_q == rcs_pkg::RCS_ST_SLEEP) begin
				cause_d = rcs_pkg::RCS_EV_EXTERNAL_MASTER_CLEAR_S; // RL1
				stat_d.timeout = 1'b1; // RL8
				stat_d.powerdown = 1'b0; // RL8
			end else if (st_q != rcs_pkg::RCS_ST_HOLD || cause_q != rcs_pkg::RCS_EV_EXTERNAL_MASTER_CLEAR_S) begin
				cause_d = rcs_pkg::RCS_EV_EXTERNAL_MASTER_CLEAR; // RL1 RL7
			end
			st_d = rcs_pkg::RCS_ST_HOLD;
			dly_d = (cause_d == rcs_pkg::RCS_EV_EXTERNAL_MASTER_CLEAR_S) ?
				READY_CYCLES[rcs_pkg::READY_W-1:0] : dly_q; // RL5
		end else begin
			unique case (st_q)
				rcs_pkg::RCS_ST_HOLD: begin
					// Release only after the delay; cause already latched
					if (dly_q == '0) begin
						st_d = rcs_pkg::RCS_ST_RUN; // RL16
					end
				end
				rcs_pkg::RCS_ST_RUN: begin
					if (watchdog_timer_ovf) begin
						cause_d = rcs_pkg::RCS_EV_WDT; // RL1
						stat_d.timeout = 1'b0; // RL9
						stat_d.powerdown = 1'b1; // RL9
						pc_d = rcs_pkg::PC_RESET; // RL9
						st_d = rcs_pkg::RCS_ST_HOLD;
					end else if (sleep_exec) begin
						stat_d.timeout = 1'b1; // RL14
						stat_d.powerdown = 1'b0; // RL14
						st_d = rcs_pkg::RCS_ST_SLEEP;
					end else if (step_pc) begin
						pc_d = pc_q + rcs_pkg::PC_STEP;
					end
				end
				rcs_pkg::RCS_ST_SLEEP: begin
					if (watchdog_timer_ovf) begin
						cause_d = rcs_pkg::RCS_EV_WDT_S; // RL1
						stat_d.timeout = 1'b0; // RL10
						stat_d.powerdown = 1'b0; // RL10
						pc_d = pc_q + rcs_pkg::PC_STEP; // RL10
						st_d = rcs_pkg::RCS_ST_WAKE;
						dly_d = READY_CYCLES[rcs_pkg::READY_W-1:0]; // RL5
					end else if (irq_wake) begin
						cause_d = rcs_pkg::RCS_EV_NONE;
						stat_d.timeout = 1'b1; // RL11
						stat_d.powerdown = 1'b0; // RL11
						pc_d = global_interrupt_enable ? rcs_pkg::PC_VECTOR :
							pc_q + rcs_pkg::PC_STEP; // RL11 RL12
						st_d = rcs_pkg::RCS_ST_WAKE;
						dly_d = READY_CYCLES[rcs_pkg::READY_W-1:0]; // RL5
					end
				end
				rcs_pkg::RCS_ST_WAKE: begin
					if (dly_q == '0) begin
						st_d = rcs_pkg::RCS_ST_RUN; // RL5
					end
				end
			endcase
		end
	end

	// Registers; rst is a power-on, so cause logic above already handles it
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= rcs_pkg::RCS_ST_HOLD;
			cause_q <= rcs_pkg::RCS_EV_POR;
			stat_q <= '{timeout: 1'b1, powerdown: 1'b1, por_n: 1'b0, bor_n: 1'b1};
			pc_q <= rcs_pkg::PC_RESET;
			dly_q <= READY_CYCLES[rcs_pkg::READY_W-1:0];
		end else if (ce) begin
			st_q <= st_d;
			cause_q <= cause_d;
			stat_q <= stat_d;
			pc_q <= pc_d;
			dly_q <= dly_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog counter, prescaler, flags and resettable register
	logic [rcs_pkg::WDOG_W-1:0] wd_q, wd_d;
	logic [rcs_pkg::WPRE_W-1:0] wp_q, wp_d;
	rcs_pkg::rcs_flags_t fl_q, fl_d;
	logic [rcs_pkg::DATA_W-1:0] cr_q, cr_d;
	logic waking;

	assign waking = st_q == rcs_pkg::RCS_ST_SLEEP && st_d == rcs_pkg::RCS_ST_WAKE;

	// Prescaler ticks the counter; sleep entry and resets clear both
	always_comb begin
		wd_d = wd_q;
		wp_d = wp_q + 16'h0001;
		fl_d = fl_q;
		cr_d = ctrl_we ? ctrl_wdata : cr_q;
		if (wp_q == '1) begin
			wd_d = wd_q + 8'h01;
		end
		if (hard_rst || (st_q == rcs_pkg::RCS_ST_RUN && sleep_exec)) begin
			wd_d = rcs_pkg::WDOG_CLEAR; // RL14
			wp_d = rcs_pkg::WPRE_CLEAR; // RL14
		end
		if (hard_rst) begin
			fl_d = '{interrupt_control_reg: rcs_pkg::IFLAG_CLEAR, pflag1: rcs_pkg::IFLAG_CLEAR,
				pflag2: rcs_pkg::IFLAG_CLEAR}; // RL3
			cr_d = rcs_pkg::CTRL_RESET; // RL3
		end else if (waking) begin
			// Only causing bits set; others keep their value
			fl_d = fl_q | wake_flags; // RL13 RL4
		end
	end

	// Registered state of this group
	always_ff @(posedge clk) begin
		if (rst) begin
			wd_q <= rcs_pkg::WDOG_CLEAR;
			wp_q <= rcs_pkg::WPRE_CLEAR;
			fl_q <= '0;
			cr_q <= rcs_pkg::CTRL_RESET;
		end else if (ce) begin
			wd_q <= wd_d;
			wp_q <= wp_d;
			fl_q <= fl_d;
			cr_q <= cr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Preserved store: never reset, written only while running
	rcs_keep_mem u_keep (
		.clk(clk),
		.ce(ce),
		.we(keep_we && st_q == rcs_pkg::RCS_ST_RUN), // RL2
		.addr(keep_addr),
		.wdata(ctrl_wdata),
		.rdata(keep_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign core_reset = st_q == rcs_pkg::RCS_ST_HOLD; // RL16
	assign core_ready = st_q == rcs_pkg::RCS_ST_RUN; // RL5
	assign osc_run = st_q != rcs_pkg::RCS_ST_SLEEP; // RL14
	assign pc = pc_q;
	assign status = stat_q;
	assign last_cause = cause_q;
	assign int_flags = fl_q;
	assign wdog_count = wd_q;
	assign wdog_pre = wp_q;
	assign ctrl_reg = cr_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_wdt_run;
		@(posedge clk) disable iff (rst)
		(ce && !por_act && !bor_act && !external_master_clear_act && st_q == rcs_pkg::RCS_ST_RUN &&
		watchdog_timer_ovf) |=> (pc == rcs_pkg::PC_RESET && !status.timeout && status.powerdown);
	endproperty
	a_wdt_run: assert property (p_wdt_run) else $error("watchdog reset status wrong"); // RL9

	property p_wdt_wake;
		@(posedge clk) disable iff (rst)
		(ce && !por_act && !bor_act && !external_master_clear_act && st_q == rcs_pkg::RCS_ST_SLEEP &&
		watchdog_timer_ovf) |=> (pc == $past(pc) + rcs_pkg::PC_STEP &&
		!status.timeout && !status.powerdown && ctrl_reg == $past(ctrl_reg));
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong"); // RL10

	property p_irq_vec;
		@(posedge clk) disable iff (rst)
		(ce && !por_act && !bor_act && !external_master_clear_act && st_q == rcs_pkg::RCS_ST_SLEEP &&
		!watchdog_timer_ovf && irq_wake && global_interrupt_enable)
		|=> (pc == rcs_pkg::PC_VECTOR && status.timeout && !status.powerdown);
	endproperty
	a_irq_vec: assert property (p_irq_vec) else $error("interrupt vector not loaded"); // RL12

	property p_sleep;
		@(posedge clk) disable iff (rst)
		(ce && !hard_rst && st_q == rcs_pkg::RCS_ST_RUN && sleep_exec)
		|=> (wdog_count == rcs_pkg::WDOG_CLEAR && !osc_run && status.timeout && !status.powerdown);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entry wrong"); // RL14

	property p_external_master_clear_run;
		@(posedge clk) disable iff (rst)
		(ce && external_master_clear_act && st_q == rcs_pkg::RCS_ST_RUN) |=> (pc == rcs_pkg::PC_RESET &&
		status.timeout == $past(status.timeout) && status.powerdown == $past(status.powerdown));
	endproperty
	a_external_master_clear_run: assert property (p_external_master_clear_run) else $error("master clear changed status"); // RL7

	property p_bor;
		@(posedge clk) disable iff (rst)
		(ce && bor_act) |=> (!status.bor_n && status.por_n == $past(status.por_n) && core_reset);
	endproperty
	a_bor: assert property (p_bor) else $error("brown-out bits wrong"); // RL15
endmodule : rcs_core
`default_nettype wire

// >>> bench/rcs_pin_model.sv
/*
 * Behavioural model of the master-clear pin and the two supply monitors.
 * Assumes one clock; a request is taken at the rising edge and the chosen
 * pin is held active for HOLD_CYC cycles, then released to its idle level.
 */
`timescale 1ns/1ns
`default_nettype none
module rcs_pin_model #(
	parameter int unsigned HOLD_CYC = 6
) (
	input wire logic clk,                  // Bench clock
	input wire logic go,                   // Start one pin event
	input wire logic [1:0] kind,           // 0 clear, 1 brown-out, 2 power-on
	output logic external_master_clear_n,  // Master clear pin
	output logic brownout_reset,           // Brown-out level
	output logic power_on_n                // Power-good, low on power-on
);
	logic [7:0] cnt_q;
	logic [1:0] kind_q;
	// Idle levels from time zero, before the first falling edge
	initial begin
		cnt_q = 8'h00;
		kind_q = 2'h0;
		external_master_clear_n = 1'b1;
		brownout_reset = 1'b0;
		power_on_n = 1'b1;
	end
	// Latch a request and count its length
	always @(posedge clk) begin
		if (go) begin
			cnt_q <= 8'(HOLD_CYC);
			kind_q <= kind;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
	// Pins move on the falling edge, away from the sampling edge
	always @(negedge clk) begin
		external_master_clear_n <= !(cnt_q != 8'h00 && kind_q == 2'h0);
		brownout_reset <= (cnt_q != 8'h00 && kind_q == 2'h1);
		power_on_n <= !(cnt_q != 8'h00 && kind_q == 2'h2);
	end
endmodule : rcs_pin_model
`default_nettype wire

// >>> bench/tb_top.sv
/*
 * Self-checking bench for rcs_core: drives reset and wake events, queues
 * the expected state, and checks it at each core start and sleep entry.
 * Assumes rcs_pkg and the pin model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [12:0] pc;
		rcs_pkg::rcs_status_t st;
		rcs_pkg::rcs_cause_t cause;
		rcs_pkg::rcs_flags_t flags;
		logic [7:0] ctrl;
	} rcs_tb_exp_t;
	localparam int unsigned RDY = 4;
	logic clk, rst, watchdog_timer_ovf, sleep_exec, irq_wake, global_interrupt_enable;
	logic ce, step_pc, ctrl_we, keep_we, pin_go, keep_ok, rdy_p, osc_p;
	logic [1:0] pin_kind;
	logic [7:0] ctrl_wdata, keep_exp;
	logic [3:0] keep_addr;
	logic [31:0] rnd;
	rcs_pkg::rcs_flags_t wake_flags;
	wire logic external_master_clear_n, brownout_reset, power_on_n, core_reset, core_ready;
	wire logic osc_run;
	wire logic [12:0] pc;
	wire rcs_pkg::rcs_status_t status;
	wire rcs_pkg::rcs_cause_t last_cause;
	wire rcs_pkg::rcs_flags_t int_flags;
	wire logic [7:0] wdog_count, ctrl_reg, keep_rdata;
	wire logic [15:0] wdog_pre;
	rcs_tb_exp_t e, x;
	rcs_tb_exp_t q[$];
	int num_errors = 0;
	int comparisons = 0;
	int g;

	rcs_pin_model pins_u (.clk(clk), .go(pin_go), .kind(pin_kind),
		.external_master_clear_n(external_master_clear_n),
		.brownout_reset(brownout_reset), .power_on_n(power_on_n));
	rcs_core #(.READY_CYCLES(RDY)) dut_u (.clk(clk), .rst(rst), .ce(ce),
		.external_master_clear_n(external_master_clear_n), .brownout_reset(brownout_reset),
		.power_on_n(power_on_n), .watchdog_timer_ovf(watchdog_timer_ovf),
		.sleep_exec(sleep_exec), .irq_wake(irq_wake),
		.global_interrupt_enable(global_interrupt_enable), .step_pc(step_pc),
		.wake_flags(wake_flags), .ctrl_wdata(ctrl_wdata), .ctrl_we(ctrl_we),
		.keep_we(keep_we), .keep_addr(keep_addr), .core_reset(core_reset),
		.core_ready(core_ready), .osc_run(osc_run), .pc(pc), .status(status),
		.last_cause(last_cause), .int_flags(int_flags), .wdog_count(wdog_count),
		.wdog_pre(wdog_pre), .ctrl_reg(ctrl_reg), .keep_rdata(keep_rdata));

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check

	task give_verdict();
		if (num_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict

	// Bounded wait: core stops, then runs again
	task settle();
		int i;
		for (i = 0; i < 100 && core_ready !== 1'b0; i++) @(negedge clk);
		for (i = 0; i < 100 && core_ready !== 1'b1; i++) @(negedge clk);
		// A core that never starts counts as a mismatch
		check(core_ready, 1'b1);
	endtask : settle

	task steps(input int n);
		repeat (n) begin
			step_pc = 1'b1;
			@(negedge clk);
		end
		step_pc = 1'b0;
		e.pc = e.pc + 13'(n);
	endtask : steps

	task wr_ctrl();
		rnd = lfsr(rnd);
		ctrl_wdata = rnd[7:0];
		ctrl_we = 1'b1;
		e.ctrl = rnd[7:0];
		@(negedge clk);
		ctrl_we = 1'b0;
	endtask : wr_ctrl

	task do_sleep();
		int i;
		e.st.timeout = 1'b1;
		e.st.powerdown = 1'b0;
		q.push_back(e);
		sleep_exec = 1'b1;
		@(negedge clk);
		sleep_exec = 1'b0;
		for (i = 0; i < 20 && osc_run !== 1'b0; i++) @(negedge clk);
		repeat (2) @(negedge clk);
	endtask : do_sleep

	// Kinds 0..2 are pin events, 3 a watchdog overflow, 4 an interrupt
	task fire(input int k, input logic with_sleep);
		if (k < 3) begin
			pin_kind = 2'(k);
			pin_go = 1'b1;
		end else if (k == 3) begin
			watchdog_timer_ovf = 1'b1;
			sleep_exec = with_sleep;
		end else begin
			irq_wake = 1'b1;
		end
		@(negedge clk);
		pin_go = 1'b0;
		watchdog_timer_ovf = 1'b0;
		sleep_exec = 1'b0;
		q.push_back(e);
		settle();
		irq_wake = 1'b0;
		wake_flags = '0;
	endtask : fire

	////////////////////////////////////////////////////////////////////////
	// Clock and watchdog; a hang counts as a mismatch
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		give_verdict();
	end

	// Monitor: a core start or a sleep entry is one result
	always @(negedge clk) begin
		if ((core_ready === 1'b1 && rdy_p === 1'b0) || (osc_run === 1'b0 && osc_p === 1'b1)) begin
			if (q.size() == 0) begin
				num_errors++;
				$display("[ERR] %0t seen %h exp %h", $time, pc, 13'h0000);
			end else begin
				x = q.pop_front();
				check({pc, status, last_cause, int_flags, ctrl_reg}, x);
				if (keep_ok) check(keep_rdata, keep_exp);
			end
			if (osc_run === 1'b0 && osc_p === 1'b1) check({wdog_count, wdog_pre}, 24'h000000);
		end
		// A stop that is not a sleep entry must hold the core in reset
		if (core_ready === 1'b0 && rdy_p === 1'b1 && osc_run === 1'b1) check(core_reset, 1'b1);
		rdy_p = core_ready;
		osc_p = osc_run;
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rst, watchdog_timer_ovf, sleep_exec, irq_wake, global_interrupt_enable} = 5'h10;
		{step_pc, ctrl_we, keep_we, pin_go, keep_ok, rdy_p, osc_p} = 7'h00;
		ce = 1'b1;
		pin_kind = 2'h0;
		ctrl_wdata = 8'h00;
		keep_addr = 4'h0;
		keep_exp = 8'h00;
		wake_flags = '0;
		rnd = 32'hf5bf;
		e = '0;
		e.st = 4'hD;
		e.cause = rcs_pkg::RCS_EV_POR;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		q.push_back(e);
		settle();
		wr_ctrl();
		rnd = lfsr(rnd);
		ctrl_wdata = rnd[7:0];
		keep_addr = rnd[11:8];
		keep_exp = rnd[7:0];
		keep_we = 1'b1;
		@(negedge clk);
		keep_we = 1'b0;
		keep_ok = 1'b1;
		steps(3);
		do_sleep();
		e.pc = e.pc + rcs_pkg::PC_STEP;
		e.st.timeout = 1'b0;
		e.st.powerdown = 1'b0;
		e.cause = rcs_pkg::RCS_EV_WDT_S;
		fire(3, 1'b0);
		// Interrupt wakes with global enable off, then on
		for (g = 0; g < 2; g++) begin
			steps(2);
			do_sleep();
			global_interrupt_enable = g[0];
			rnd = lfsr(rnd);
			wake_flags = rnd[23:0];
			e.flags = e.flags | rnd[23:0];
			e.pc = g ? rcs_pkg::PC_VECTOR : e.pc + rcs_pkg::PC_STEP;
			e.cause = rcs_pkg::RCS_EV_NONE;
			fire(4, 1'b0);
		end
		// Master clear while running keeps the status pair
		e.pc = 13'h0000;
		e.cause = rcs_pkg::RCS_EV_EXTERNAL_MASTER_CLEAR;
		e.flags = '0;
		e.ctrl = 8'h00;
		fire(0, 1'b0);
		// Clock enable low: requested steps must leave the PC frozen
		ce = 1'b0;
		steps(2);
		ce = 1'b1;
		e.pc = 13'h0000;
		steps(1);
		do_sleep();
		e.pc = 13'h0000;
		e.cause = rcs_pkg::RCS_EV_EXTERNAL_MASTER_CLEAR_S;
		fire(0, 1'b0);
		// Watchdog wins over a sleep in the same cycle
		steps(2);
		wr_ctrl();
		e.pc = 13'h0000;
		e.st.timeout = 1'b0;
		e.st.powerdown = 1'b1;
		e.cause = rcs_pkg::RCS_EV_WDT;
		e.ctrl = 8'h00;
		fire(3, 1'b1);
		steps(2);
		e.pc = 13'h0000;
		e.st = {2'b11, e.st.por_n, 1'b0};
		e.cause = rcs_pkg::RCS_EV_BOR;
		fire(1, 1'b0);
		steps(1);
		e.st = 4'hD;
		e.pc = 13'h0000;
		e.cause = rcs_pkg::RCS_EV_POR;
		fire(2, 1'b0);
		repeat (5) @(negedge clk);
		// Every queued result must have shown up
		check(q.size(), 0);
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
